// ---- rtl/sysin_defs.svh ----
// offsets, command codes, error codes and timing for the system inputs
`ifndef SYSIN_DEFS_SVH
`define SYSIN_DEFS_SVH
// register byte offsets
`define REG_CMD 4'h0
`define REG_FILT 4'h4
`define REG_STAT 4'h8
`define REG_ERR 4'hC
// command codes in CMD[3:0]
`define CMD_START 4'h1
`define CMD_MODE 4'h2
`define CMD_MOTOR 4'h3
`define CMD_MANUAL 4'h4
// error codes
`define ERR_AUTO_LOST 16'h21FC
`define ERR_MANUAL_WHILE_PERMIT 16'h21F2
`define ERR_AUTO_WITHOUT_PERMIT 16'h21F3
`define ERR_MODE_RESTRICTED 16'h21FD
`define ERR_HALT_OPEN 16'h2008
// selectability classes
`define CLS_OK 2'h0
`define CLS_PART 2'h1
`define CLS_NO 2'h2
// timing
`define IMM_MIN_MS 50
`define CLK_KHZ 40000
`define FILT_W 24
`endif

// ---- rtl/sysin_pkg.sv ----
// types shared by the system input interlock
package sysin_pkg;
	typedef enum logic [1:0] {
		MODE_MAN,
		MODE_TEACH,
		MODE_INT,
		MODE_EXT
	} mode_t;
	typedef enum logic [2:0] {
		IDLE_S,
		RUN_S,
		STEP_S,
		SUSP_S,
		DECEL_S
	} run_t;
	// contact inputs, 1 = shorted
	typedef struct packed {
		logic skip;
		logic imm_run;
		logic step_run;
		logic halt_ok;
		logic permit;
	} contacts_t;
	typedef struct packed {
		logic pendant;
		logic local_auto;
		logic panel_halt;
		logic step_done;
		logic decel_done;
		logic prog_end;
		logic motion;
		logic skip_window;
	} core_t;
	typedef struct packed {
		mode_t mode;
		logic motor_on;
		logic in_operation;
		logic ext_mode;
		logic auto_mode;
		logic decel_req;
		logic imm_stop;
		logic skip_step;
		logic start_open;
		logic restart_first;
	} ctl_t;
endpackage

// ---- rtl/system_input_mode_interlock.sv ----
// system input interlock: mode gating, halt, stops and motion skip
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "sysin_defs.svh"
module system_input_mode_interlock #(
	parameter int unsigned IMM_MIN_CYC = `IMM_MIN_MS * `CLK_KHZ,
	parameter int unsigned FILT_W = `FILT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// contacts and robot core
	input sysin_pkg::contacts_t contacts,
	input sysin_pkg::core_t core,
	// control and errors
	output sysin_pkg::ctl_t ctl,
	output logic [15:0] err_code,
	output logic err_pulse,
	output logic err_auto_without_permit
);
	import sysin_pkg::*;

	if (FILT_W < 2 || FILT_W > 31 || IMM_MIN_CYC < 1 ||
			IMM_MIN_CYC >= (64'h1 << FILT_W)) begin : g_bad
		$error("filter width cannot hold IMM_MIN_CYC");
	end

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic is_auto(input mode_t m);
		return m == MODE_INT || m == MODE_EXT;
	endfunction

	function automatic logic [1:0] sel_class(input mode_t m,
			input logic permit, input logic pend);
		if (!pend && m == MODE_INT)
			return `CLS_OK;
		if (is_auto(m))
			return permit ? `CLS_OK : `CLS_NO;
		return permit ? `CLS_PART : `CLS_OK;
	endfunction

	// ---------------------------------------------------------------
	// contact synchroniser
	// ---------------------------------------------------------------
	logic [4:0] s1;
	logic [4:0] s2;
	logic [4:0] s3;
	always_ff @(posedge clk) begin
		if (srst) begin
			s1 <= 5'h0;
			s2 <= 5'h0;
			s3 <= 5'h0;
		end else begin
			s1 <= contacts;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// edges seen only between stage two and three
	wire [4:0] fall = s3 & ~s2;
	wire [4:0] rise = ~s3 & s2;
	wire permit = s2[0];
	wire halt_ok = s2[1];
	wire skip_in = s2[4];

	// ---------------------------------------------------------------
	// immediate-stop width filter
	// ---------------------------------------------------------------
	logic [FILT_W-1:0] filt_len;
	logic [FILT_W-1:0] imm_cnt;
	wire [FILT_W-1:0] filt_eff = (filt_len == '0) ? FILT_W'(1) : filt_len;
	// fires once, when the opening has lasted the programmed width
	wire imm_fall = !s2[3] && (imm_cnt == filt_eff - FILT_W'(1));
	always_ff @(posedge clk) begin
		if (srst)
			imm_cnt <= '0;
		else if (s2[3])
			imm_cnt <= '0;
		else if (imm_cnt != filt_eff)
			imm_cnt <= imm_cnt + FILT_W'(1);
	end

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire acc = (read || write) && !waitrequest;
	wire cmd_wr = acc && write && address == `REG_CMD;
	wire filt_wr = acc && write && address == `REG_FILT;
	wire err_wr = acc && write && address == `REG_ERR;
	wire [3:0] code = writedata[3:0];
	wire mode_t marg = mode_t'(writedata[5:4]);
	wire c_start = cmd_wr && code == `CMD_START;
	wire c_mode = cmd_wr && code == `CMD_MODE;
	wire c_motor = cmd_wr && code == `CMD_MOTOR;
	wire c_manual = cmd_wr && code == `CMD_MANUAL;

	// ---------------------------------------------------------------
	// state and conditions
	// ---------------------------------------------------------------
	run_t st;
	run_t next_st;
	logic [1:0] cls_q;
	logic f3_q;
	wire halt_act = !halt_ok || core.panel_halt;
	wire running = st == RUN_S || st == STEP_S;
	wire manlike = ctl.mode == MODE_MAN || ctl.mode == MODE_TEACH;
	wire [1:0] cls_now = sel_class(ctl.mode, permit, core.pendant);
	wire start_ok = is_auto(ctl.mode) && core.pendant && permit &&
		ctl.motor_on && (st == IDLE_S || st == SUSP_S);
	wire mode_ok = (marg == MODE_EXT) ? (core.pendant && permit) :
		(!is_auto(marg) || permit || !core.pendant);
	wire permit_drop = fall[0] && is_auto(ctl.mode) && core.pendant;
	wire do_skip = rise[4] && st == RUN_S && core.motion &&
		core.skip_window && !halt_act;

	// ---------------------------------------------------------------
	// error detection
	// ---------------------------------------------------------------
	wire e_halt = halt_act && (c_motor || c_manual || c_start);
	wire e_lost = permit_drop && running;
	wire e_man = c_manual && permit && manlike;
	wire f3_now = core.local_auto && !permit && core.pendant;
	wire e_f3 = f3_now && !f3_q;
	wire e_fd = cls_q == `CLS_OK && cls_now != `CLS_OK &&
		!e_lost;
	wire any_err = e_halt || e_lost || e_man || e_f3 || e_fd;
	wire [15:0] next_err = e_halt ? `ERR_HALT_OPEN :
		e_lost ? `ERR_AUTO_LOST :
		e_man ? `ERR_MANUAL_WHILE_PERMIT :
		e_f3 ? `ERR_AUTO_WITHOUT_PERMIT : `ERR_MODE_RESTRICTED;

	// ---------------------------------------------------------------
	// run sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (halt_act) begin
			case (st)
				RUN_S,
				STEP_S: next_st = DECEL_S;
				DECEL_S: next_st = core.decel_done ? IDLE_S : DECEL_S;
				default: next_st = IDLE_S;
			endcase
		end else if (e_lost) begin
			next_st = IDLE_S;
		end else begin
			case (st)
				RUN_S: begin
					if (imm_fall)
						next_st = SUSP_S;
					else if (fall[2])
						next_st = STEP_S;
					else if (core.prog_end)
						next_st = IDLE_S;
				end
				STEP_S: begin
					if (imm_fall || core.step_done)
						next_st = SUSP_S;
				end
				IDLE_S,
				SUSP_S: begin
					if (c_start && start_ok)
						next_st = RUN_S;
				end
				DECEL_S: next_st = IDLE_S;
				default: next_st = IDLE_S;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// mode and motor selection
	// ---------------------------------------------------------------
	wire halt_done = halt_act && st == DECEL_S && core.decel_done;
	// permit loss drops external mode even during a halt
	wire mode_t next_mode = permit_drop ? MODE_MAN :
		(halt_done && ctl.mode == MODE_EXT) ? MODE_INT :
		(c_mode && mode_ok && !running && !halt_act) ? marg : ctl.mode;
	wire next_motor = (halt_act && next_st != DECEL_S) ? 1'b0 :
		(c_motor && !halt_act) ? 1'b1 : ctl.motor_on;
	wire next_restart = (halt_act && st != IDLE_S) ? 1'b1 :
		do_skip ? 1'b1 :
		(next_st == RUN_S && !running) ? 1'b0 : ctl.restart_first;
	wire next_inop = next_st == RUN_S || next_st == STEP_S;

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= IDLE_S;
			ctl <= '0;
			cls_q <= `CLS_OK;
		end else begin
			st <= next_st;
			cls_q <= sel_class(next_mode, permit, core.pendant);
			ctl.mode <= next_mode;
			ctl.motor_on <= next_motor;
			ctl.in_operation <= next_inop;
			ctl.ext_mode <= next_mode == MODE_EXT;
			ctl.auto_mode <= is_auto(next_mode);
			ctl.decel_req <= next_st == DECEL_S;
			ctl.imm_stop <= imm_fall && running && !halt_act;
			ctl.skip_step <= do_skip;
			ctl.start_open <= skip_in;
			ctl.restart_first <= next_restart;
		end
	end

	// ---------------------------------------------------------------
	// error outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			err_code <= 16'h0000;
			err_pulse <= 1'b0;
			f3_q <= 1'b0;
			err_auto_without_permit <= 1'b0;
		end else begin
			f3_q <= f3_now;
			err_auto_without_permit <= f3_now;
			err_pulse <= any_err;
			// a new error wins over a software clear
			if (any_err)
				err_code <= next_err;
			else if (err_wr)
				err_code <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	wire [31:0] stat = {22'h0, halt_act, f3_q, ctl.restart_first,
		st == SUSP_S, ctl.auto_mode, ctl.ext_mode, ctl.in_operation,
		ctl.motor_on, ctl.mode};
	wire [31:0] rd_mux = (address == `REG_FILT) ?
		{{(32 - FILT_W){1'b0}}, filt_len} :
		(address == `REG_STAT) ? stat :
		(address == `REG_ERR) ? {16'h0, err_code} : 32'h0;

	// one wait cycle per access; data stands with waitrequest low
	always_ff @(posedge clk) begin
		if (srst) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0;
			filt_len <= FILT_W'(IMM_MIN_CYC);
		end else begin
			waitrequest <= !((read || write) && waitrequest);
			if (read && waitrequest)
				readdata <= rd_mux;
			if (filt_wr)
				filt_len <= writedata[FILT_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence halt_idle;
		halt_act && (st == IDLE_S || st == SUSP_S);
	endsequence
	sequence decel_end;
		st == DECEL_S && halt_act && core.decel_done;
	endsequence
	sequence step_wait;
		st == STEP_S && !core.step_done && !halt_act && !imm_fall &&
			!e_lost;
	endsequence

	AST_HALT_POWER: assert property (halt_idle |=> !ctl.motor_on)
		else $error("motor on while halted");
	AST_HALT_FIRST: assert property (
		halt_act && st == RUN_S |=> st == DECEL_S && ctl.decel_req)
		else $error("halt did not win over other inputs");
	AST_DECEL_OFF: assert property (decel_end |=>
		!ctl.motor_on && ctl.mode != MODE_EXT && st == IDLE_S)
		else $error("halt end left power or external mode");
	AST_STEP_HOLD: assert property (step_wait |=>
		st == STEP_S && ctl.in_operation)
		else $error("step stop left before step end");
	AST_AUTO_LOST: assert property (e_lost && !halt_act |=>
		err_pulse && err_code == `ERR_AUTO_LOST && ctl.mode == MODE_MAN)
		else $error("auto loss not reported");
	AST_F3_LEVEL: assert property (f3_now [*2] |=>
		err_auto_without_permit && $stable(err_auto_without_permit))
		else $error("selector error not held");
	AST_NO_REVERSE: assert property (
		cls_q != `CLS_OK && cls_now == `CLS_OK && !any_err |=> !err_pulse)
		else $error("error on return to selectable mode");
	AST_EXT_DROP: assert property (
		fall[0] && ctl.mode == MODE_EXT && core.pendant |=> !ctl.ext_mode)
		else $error("external mode kept after permit open");
	AST_SKIP: assert property (do_skip |=>
		ctl.skip_step && ctl.restart_first ##1 !ctl.skip_step)
		else $error("skip not a one-cycle step abort");
	AST_IMM_RESUME: assert property (
		imm_fall && st == RUN_S && !halt_act && !e_lost |=>
		st == SUSP_S && !ctl.in_operation && ctl.mode == $past(ctl.mode))
		else $error("immediate stop mishandled");
	AST_HALT_ERR: assert property (e_halt |=>
		err_code == `ERR_HALT_OPEN && !ctl.motor_on)
		else $error("halt refusal not reported");
endmodule // system_input_mode_interlock

// ---- tb/plc_model.sv ----
// far-side model: outside sequence contacts and robot core status
`timescale 1ns/1ps
module plc_model (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// levels the bench asks for
	input sysin_pkg::contacts_t want_c,
	input sysin_pkg::core_t want_k,
	input wire logic slow,
	// block outputs seen by the far side
	input sysin_pkg::ctl_t ctl,
	// levels driven into the block
	output sysin_pkg::contacts_t contacts,
	output sysin_pkg::core_t core
);
	import sysin_pkg::*;
	logic [5:0] step_cnt;
	logic [5:0] stop_cnt;
	logic estop_req;
	core_t next_core;
	always_comb begin
		next_core = want_k;
		// steps end every 16 cycles, so a step stop must wait
		next_core.step_done = step_cnt[3:0] == 4'hF;
		next_core.decel_done = stop_cnt >= (slow ? 6'h28 : 6'h03);
	end
	// outside logic would trip its emergency stop on this
	assign estop_req = !contacts.permit && ctl.auto_mode;
	// ----------------------------------------
	// contacts follow the bench one edge late
	// ----------------------------------------
	always @(posedge clk) begin
		contacts <= want_c;
		core <= next_core;
		step_cnt <= (srst || !ctl.in_operation) ? 6'h0 : step_cnt + 6'h1;
		stop_cnt <= (srst || !ctl.decel_req) ? 6'h0 : stop_cnt + 6'h1;
	end
endmodule // plc_model

// ---- tb/system_input_mode_interlock_tb.sv ----
// testbench for the system input interlock
`timescale 1ns/1ps
`include "sysin_defs.svh"
module system_input_mode_interlock_tb;
	import sysin_pkg::*;
	logic clk;
	logic srst;
	logic [3:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	contacts_t contacts;
	core_t core;
	ctl_t ctl;
	logic [15:0] err_code;
	logic err_pulse;
	logic err_auto_without_permit;
	contacts_t want_c;
	core_t want_k;
	logic slow;
	logic [31:0] q;
	logic imm_seen = 1'b0;
	logic skip_seen = 1'b0;
	int err_pulses = 0;
	int e0;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	system_input_mode_interlock #(.IMM_MIN_CYC(20)) u_dut (
		.clk(clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .contacts(contacts), .core(core),
		.ctl(ctl), .err_code(err_code), .err_pulse(err_pulse),
		.err_auto_without_permit(err_auto_without_permit));
	plc_model u_plc (.clk(clk), .srst(srst), .want_c(want_c),
		.want_k(want_k), .slow(slow), .ctl(ctl), .contacts(contacts),
		.core(core));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// one-cycle pulses are latched so no edge is missed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (ctl.imm_stop === 1'b1) imm_seen <= 1'b1;
		if (ctl.skip_step === 1'b1) skip_seen <= 1'b1;
		if (err_pulse === 1'b1) err_pulses <= err_pulses + 1;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chb(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic bw(input logic [3:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic br(input logic [3:0] a);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		want_c = 5'h0F;
		want_k = 8'h80;
		slow = 1'b0;
		settle(5);
		srst <= 1'b0;
		settle(3);
		chk(32'(ctl), 32'h0);
		br(`REG_STAT);
		chk(q, 32'h0);
		br(4'h2);
		chk(q, 32'h0);
		e0 = err_pulses;
		bw(`REG_CMD, 32'(`CMD_MANUAL));
		br(`REG_ERR);
		chk(q, 32'(`ERR_MANUAL_WHILE_PERMIT));
		chk(32'(err_pulses - e0), 32'h1);
		bw(`REG_ERR, 32'h0);
		bw(`REG_CMD, 32'h22);
		br(`REG_ERR);
		chk(q, 32'h0);
		chk(32'(ctl.mode), 32'(MODE_INT));
		bw(`REG_FILT, 32'h14);
		br(`REG_FILT);
		chk(q, 32'h14);
		bw(`REG_CMD, 32'(`CMD_MOTOR));
		bw(`REG_CMD, 32'(`CMD_START));
		chb(ctl.in_operation, 1'b1);
		$display("test setup done");
		want_c.step_run <= 1'b0;
		settle(40);
		chb(ctl.in_operation, 1'b0);
		chk(32'(ctl.mode), 32'(MODE_INT));
		want_c.step_run <= 1'b1;
		settle(6);
		bw(`REG_CMD, 32'(`CMD_START));
		chb(ctl.in_operation, 1'b1);
		$display("test step stop done");
		want_c.imm_run <= 1'b0;
		settle(5);
		want_c.imm_run <= 1'b1;
		settle(30);
		chb(imm_seen, 1'b0);
		chb(ctl.in_operation, 1'b1);
		want_c.imm_run <= 1'b0;
		settle(30);
		chb(imm_seen, 1'b1);
		chb(ctl.in_operation, 1'b0);
		chk(32'(ctl.mode), 32'(MODE_INT));
		want_c.imm_run <= 1'b1;
		settle(6);
		bw(`REG_CMD, 32'(`CMD_START));
		chb(ctl.in_operation, 1'b1);
		$display("test immediate stop done");
		want_k.motion <= 1'b1;
		want_c.skip <= 1'b1;
		settle(8);
		chb(skip_seen, 1'b0);
		want_c.skip <= 1'b0;
		want_k.skip_window <= 1'b1;
		settle(6);
		// no start command is pending while skip is shorted
		want_c.skip <= 1'b1;
		settle(8);
		chb(skip_seen, 1'b1);
		chb(ctl.start_open, 1'b1);
		chb(ctl.restart_first, 1'b1);
		want_c.skip <= 1'b0;
		want_k.motion <= 1'b0;
		want_k.skip_window <= 1'b0;
		settle(6);
		$display("test skip done");
		bw(`REG_ERR, 32'h0);
		want_c.permit <= 1'b0;
		settle(6);
		chk(32'(ctl.mode), 32'(MODE_MAN));
		br(`REG_ERR);
		chk(q, 32'(`ERR_AUTO_LOST));
		want_c.permit <= 1'b1;
		settle(6);
		bw(`REG_ERR, 32'h0);
		bw(`REG_CMD, 32'h32);
		chb(ctl.ext_mode, 1'b1);
		want_c.permit <= 1'b0;
		settle(6);
		chb(ctl.ext_mode, 1'b0);
		br(`REG_ERR);
		chk(q, 32'(`ERR_MODE_RESTRICTED));
		want_k.local_auto <= 1'b1;
		settle(6);
		chb(err_auto_without_permit, 1'b1);
		settle(20);
		chb(err_auto_without_permit, 1'b1);
		want_k.local_auto <= 1'b0;
		want_c.permit <= 1'b1;
		settle(6);
		chb(err_auto_without_permit, 1'b0);
		$display("test permit done");
		bw(`REG_CMD, 32'h32);
		bw(`REG_CMD, 32'(`CMD_MOTOR));
		bw(`REG_CMD, 32'(`CMD_START));
		slow <= 1'b1;
		want_c.halt_ok <= 1'b0;
		settle(6);
		chb(ctl.decel_req, 1'b1);
		chb(ctl.motor_on, 1'b1);
		settle(60);
		chb(ctl.motor_on, 1'b0);
		chk(32'(ctl.mode), 32'(MODE_INT));
		chb(ctl.restart_first, 1'b1);
		bw(`REG_ERR, 32'h0);
		bw(`REG_CMD, 32'(`CMD_START));
		br(`REG_ERR);
		chk(q, 32'(`ERR_HALT_OPEN));
		chb(ctl.in_operation, 1'b0);
		want_c.halt_ok <= 1'b1;
		settle(6);
		bw(`REG_CMD, 32'(`CMD_MOTOR));
		chb(ctl.motor_on, 1'b1);
		want_k.panel_halt <= 1'b1;
		settle(4);
		chb(ctl.motor_on, 1'b0);
		want_k.panel_halt <= 1'b0;
		$display("test halt done");
		want_k.pendant <= 1'b0;
		want_c.permit <= 1'b0;
		settle(6);
		bw(`REG_CMD, 32'h22);
		chk(32'(ctl.mode), 32'(MODE_INT));
		bw(`REG_CMD, 32'h32);
		chk(32'(ctl.mode), 32'(MODE_INT));
		bw(`REG_CMD, 32'(`CMD_MOTOR));
		bw(`REG_CMD, 32'(`CMD_START));
		chb(ctl.in_operation, 1'b0);
		$display("test pendantless done");
		final_report();
	end
endmodule // system_input_mode_interlock_tb
